//--- rct_pkg.sv
// Constants, command codes and timing figures of the rheostat command timing block.
// Assumes a 100 MHz core clock; every count below is derived from that period.
package rct_pkg;
  localparam int unsigned CLK_PERIOD_PS     = 10000;
  localparam int unsigned WIPER_BITS        = 10;
  localparam int unsigned STORE_DEPTH       = 50;
  localparam int unsigned STORE_ADDR_BITS   = 6;
  localparam logic [9:0]  WIPER_MIDSCALE    = 10'h0_200;
  localparam logic [9:0]  WIPER_RESET_VALUE = 10'h0_000;
  // Times as printed
  localparam int unsigned SPIKE_NS          = 50;
  localparam int unsigned RESET_PULSE_NS    = 20;
  localparam int unsigned EXEC_MIN_NS       = 500;
  localparam int unsigned WRITE_PERF_NS     = 2000;
  localparam int unsigned WRITE_NORMAL_NS   = 600;
  localparam int unsigned READBACK_US       = 6;
  localparam int unsigned PROGRAM_MS        = 350;
  localparam int unsigned RESET_RESTORE_US  = 600;
  localparam int unsigned POWERUP_MS        = 2;
  // Least times round up, longest times round down
  localparam int unsigned SPIKE_CYC   = SPIKE_NS * 1000 / CLK_PERIOD_PS;
  localparam int unsigned RESET_CYC   = (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned EXEC_MIN_CYC  = (EXEC_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WRITE_PERF_CYC   = WRITE_PERF_NS * 1000 / CLK_PERIOD_PS;
  localparam int unsigned WRITE_NORMAL_CYC = WRITE_NORMAL_NS * 1000 / CLK_PERIOD_PS;
  localparam int unsigned READBACK_CYC     = READBACK_US * 1000000 / CLK_PERIOD_PS;
  localparam longint unsigned PROGRAM_CYC  = 64'(PROGRAM_MS) * 64'd1000000000 / CLK_PERIOD_PS;
  localparam int unsigned RESET_RESTORE_CYC = RESET_RESTORE_US * 1000000 / CLK_PERIOD_PS;
  localparam int unsigned POWERUP_CYC  = POWERUP_MS * 1000000000 / CLK_PERIOD_PS;
  typedef enum logic [1:0] {
    CMD_NOP,
    CMD_WRITE_WIPER,
    CMD_READ_STORE,
    CMD_PROGRAM_STORE
  } rct_cmd_type;
endpackage : rct_pkg

//--- rct_store_if.sv
// Port bundle between the command core and the one-time wiper store.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface rct_store_if;
  logic                                write_en;
  logic [rct_pkg::STORE_ADDR_BITS-1:0] write_addr;
  logic [rct_pkg::WIPER_BITS-1:0]      write_data;
  logic [rct_pkg::STORE_ADDR_BITS-1:0] read_addr;
  logic [rct_pkg::WIPER_BITS-1:0]      read_data;
  modport core  (output write_en, output write_addr, output write_data, output read_addr,
                 input read_data);
  modport store (input write_en, input write_addr, input write_data, input read_addr,
                 output read_data);
endinterface : rct_store_if
`default_nettype wire

//--- rct_store.sv
// One-time wiper store: small memory with a registered read port.
// Assumes the core writes each location only once.
`timescale 1ns/1ps
`default_nettype none
module rct_store (
  input  wire logic   clk,
  rct_store_if.store  port
);
  logic [rct_pkg::WIPER_BITS-1:0] mem [rct_pkg::STORE_DEPTH];
  logic [rct_pkg::WIPER_BITS-1:0] rdata_reg;

  always_ff @(posedge clk) begin
    if (port.write_en) begin
      mem[port.write_addr] <= port.write_data;
    end
    rdata_reg <= mem[port.read_addr];
  end
  assign port.read_data = rdata_reg;
endmodule : rct_store
`default_nettype wire

//--- rct_spike_filter.sv
// Two-flop synchroniser and spike filter for one serial pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module rct_spike_filter #(
  parameter int unsigned SPIKE_CYC = rct_pkg::SPIKE_CYC
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pin,
  output logic      clean
);
  logic       meta_reg, sync_reg, clean_reg, clean_next;
  logic [7:0] cnt_reg, cnt_next;

  always_comb begin
    clean_next = clean_reg;
    cnt_next   = 8'h00;
    // A level must outlast the spike width before it is believed
    if (sync_reg != clean_reg) begin
      if (cnt_reg >= 8'(SPIKE_CYC)) begin
        clean_next = sync_reg;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_reg  <= 1'b1;
      sync_reg  <= 1'b1;
      clean_reg <= 1'b1;
      cnt_reg   <= 8'h00;
    end else begin
      meta_reg  <= pin;
      sync_reg  <= meta_reg;
      clean_reg <= clean_next;
      cnt_reg   <= cnt_next;
    end
  end
  assign clean = clean_reg;
endmodule : rct_spike_filter
`default_nettype wire

//--- rct_core.sv
// Command execution and wiper restore timing of a digital rheostat.
// Assumes commands arrive on the link clock with a request/accept handshake,
// and that scl, sda, reset_pin_n and perf_mode are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Spikes under 50 ns on serial clock and data never reach the filtered outputs.
// - Every command keeps the core busy at least 500 ns before completing.
// - Wiper write in performance mode completes within 2 us.
// - Wiper write in normal mode completes within 600 ns.
// - Store readback data is valid within 6 us, not earlier.
// - Store programming takes up to 350 ms; host waits before next command.
// - After a reset pulse the wiper reloads from the store within 600 us.
// - After power-up the wiper loads the midscale code within 2 ms; reset clears the programmed count.
// - A low reset pin copies the stored wiper value into the wiper register.
// - While nothing is programmed, restore loads the midscale code.
module rct_core #(
  parameter longint unsigned PROGRAM_CYC       = rct_pkg::PROGRAM_CYC,
  parameter int unsigned     RESET_RESTORE_CYC = rct_pkg::RESET_RESTORE_CYC,
  parameter int unsigned     POWERUP_CYC       = rct_pkg::POWERUP_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          link_clk,
  input  wire logic                          link_rstn,
  input  wire logic                          scl,
  input  wire logic                          sda,
  input  wire logic                          reset_pin_n,
  input  wire logic                          perf_mode,
  input  wire logic                          cmd_valid,
  input  wire rct_pkg::rct_cmd_type          cmd_code,
  input  wire logic [rct_pkg::WIPER_BITS-1:0] cmd_data,
  output logic                               cmd_pending,
  output logic                               scl_clean,
  output logic                               sda_clean,
  output logic [rct_pkg::WIPER_BITS-1:0]     wiper_setting_register,
  output logic [rct_pkg::WIPER_BITS-1:0]     readback_data,
  output logic                               readback_valid,
  output logic [rct_pkg::STORE_ADDR_BITS-1:0] programmed_count,
  output logic                               busy
);
  typedef enum logic [1:0] {ST_POWERUP, ST_IDLE, ST_EXEC, ST_RESTORE} rct_state_type;

  // Link domain: capture a command, toggle a request, wait for the echoed toggle
  rct_pkg::rct_cmd_type             lk_cmd_reg, lk_cmd_next;
  logic [rct_pkg::WIPER_BITS-1:0]   lk_data_reg, lk_data_next;
  logic lk_req_reg, lk_req_next, lk_ack_meta_reg, lk_ack_sync_reg;
  logic lk_pend_reg, lk_pend_next;
  // Core side toggle, echoed back across to the link domain
  logic ack_reg, ack_next;

  always_comb begin
    lk_cmd_next  = lk_cmd_reg;
    lk_data_next = lk_data_reg;
    lk_req_next  = lk_req_reg;
    lk_pend_next = (lk_req_reg != lk_ack_sync_reg);
    // Data stays frozen while a request is outstanding, so the core may read it
    if (!lk_pend_reg && (lk_req_reg == lk_ack_sync_reg) && cmd_valid) begin
      lk_cmd_next  = cmd_code;
      lk_data_next = cmd_data;
      lk_req_next  = ~lk_req_reg;
      lk_pend_next = 1'b1;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rstn) begin
      lk_cmd_reg      <= rct_pkg::CMD_NOP;
      lk_data_reg     <= 10'h0_000;
      lk_req_reg      <= 1'b0;
      lk_ack_meta_reg <= 1'b0;
      lk_ack_sync_reg <= 1'b0;
      lk_pend_reg     <= 1'b0;
    end else begin
      lk_cmd_reg      <= lk_cmd_next;
      lk_data_reg     <= lk_data_next;
      lk_req_reg      <= lk_req_next;
      lk_ack_meta_reg <= ack_reg;
      lk_ack_sync_reg <= lk_ack_meta_reg;
      lk_pend_reg     <= lk_pend_next;
    end
  end
  assign cmd_pending = lk_pend_reg;

  // Pin synchronisers and spike filters
  logic [1:0] serial_pins, serial_clean;
  assign serial_pins = {sda, scl};
  for (genvar i = 0; i < 2; i++) begin : g_filter
    rct_spike_filter u_filter (
      .clk   (clk),
      .rstn  (rstn),
      .pin   (serial_pins[i]),
      .clean (serial_clean[i])
    );
  end
  assign scl_clean = serial_clean[0];
  assign sda_clean = serial_clean[1];

  logic rp_meta_reg, rp_sync_reg, pm_meta_reg, pm_sync_reg;
  logic req_meta_reg, req_sync_reg;

  // Store
  rct_store_if store_bus ();
  rct_store u_store (
    .clk  (clk),
    .port (store_bus.store)
  );

  // Core state
  rct_state_type                     state_reg, state_next;
  rct_pkg::rct_cmd_type              op_reg, op_next;
  logic [31:0]                       cnt_reg, cnt_next;
  logic [7:0]                        low_cnt_reg, low_cnt_next;
  logic                              busy_reg;
  logic [rct_pkg::WIPER_BITS-1:0]    wiper_reg, wiper_next, rb_reg, rb_next;
  logic                              rb_valid_reg, rb_valid_next;
  logic [rct_pkg::STORE_ADDR_BITS-1:0] count_reg, count_next, raddr_reg, raddr_next;
  logic [rct_pkg::WIPER_BITS-1:0]    op_data_reg, op_data_next;
  logic                              reset_hit;

  // Cycle counts, each floored at the least execute time
  function automatic logic [31:0] at_least_exec(input longint unsigned cyc);
    longint unsigned c;
    c = (cyc < rct_pkg::EXEC_MIN_CYC) ? longint'(rct_pkg::EXEC_MIN_CYC) : cyc;
    return 32'(c - 1);
  endfunction : at_least_exec

  // A reset pulse counts once it has been seen low for the least pulse time
  assign reset_hit = (low_cnt_reg == 8'(rct_pkg::RESET_CYC - 1)) && !rp_sync_reg;

  always_comb begin
    state_next    = state_reg;
    op_next       = op_reg;
    cnt_next      = cnt_reg;
    ack_next      = ack_reg;
    wiper_next    = wiper_reg;
    rb_next       = rb_reg;
    rb_valid_next = rb_valid_reg;
    count_next    = count_reg;
    raddr_next    = raddr_reg;
    op_data_next  = op_data_reg;
    low_cnt_next  = rp_sync_reg ? 8'h00 :
                    (low_cnt_reg == 8'hff) ? low_cnt_reg : low_cnt_reg + 8'h01;
    store_bus.write_en   = 1'b0;
    store_bus.write_addr = count_reg;
    store_bus.write_data = wiper_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req_sync_reg != ack_reg) begin
          ack_next      = req_sync_reg;
          op_next       = lk_cmd_reg;
          op_data_next  = lk_data_reg;
          rb_valid_next = 1'b0;
          state_next    = ST_EXEC;
          raddr_next    = lk_data_reg[rct_pkg::STORE_ADDR_BITS-1:0];
          case (lk_cmd_reg)
            rct_pkg::CMD_WRITE_WIPER:
              cnt_next = perf_sel(pm_sync_reg);
            rct_pkg::CMD_READ_STORE:
              cnt_next = at_least_exec(rct_pkg::READBACK_CYC);
            rct_pkg::CMD_PROGRAM_STORE:
              cnt_next = at_least_exec(PROGRAM_CYC);
            default:
              cnt_next = at_least_exec(0);
          endcase
        end
      end
      ST_EXEC: begin
        if (cnt_reg != 32'h0000_0000) begin
          cnt_next = cnt_reg - 32'h0000_0001;
        end else begin
          state_next = ST_IDLE;
          case (op_reg)
            rct_pkg::CMD_WRITE_WIPER: wiper_next = op_data_reg;
            rct_pkg::CMD_READ_STORE: begin
              rb_next       = store_bus.read_data;
              rb_valid_next = 1'b1;
            end
            rct_pkg::CMD_PROGRAM_STORE: begin
              // A full store ignores further programming
              if (count_reg < 6'(rct_pkg::STORE_DEPTH)) begin
                store_bus.write_en = 1'b1;
                count_next         = count_reg + 6'h01;
              end
            end
            default: ;
          endcase
        end
      end
      ST_POWERUP, ST_RESTORE: begin
        raddr_next = (count_reg == 6'h00) ? 6'h00 : count_reg - 6'h01;
        if (cnt_reg != 32'h0000_0000) begin
          cnt_next = cnt_reg - 32'h0000_0001;
        end else begin
          state_next = ST_IDLE;
          wiper_next = (count_reg == 6'h00) ? rct_pkg::WIPER_MIDSCALE
                                            : store_bus.read_data;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // A reset pulse aborts whatever runs and restarts the restore
    if (reset_hit) begin
      state_next = ST_RESTORE;
      cnt_next   = at_least_exec(RESET_RESTORE_CYC);
    end
  end

  function automatic logic [31:0] perf_sel(input logic perf);
    return perf ? at_least_exec(rct_pkg::WRITE_PERF_CYC)
                : at_least_exec(rct_pkg::WRITE_NORMAL_CYC);
  endfunction : perf_sel

  assign store_bus.read_addr = raddr_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg    <= ST_POWERUP;
      busy_reg     <= 1'b1;
      op_reg       <= rct_pkg::CMD_NOP;
      cnt_reg      <= 32'(POWERUP_CYC - 1);
      ack_reg      <= 1'b0;
      wiper_reg    <= rct_pkg::WIPER_RESET_VALUE;
      rb_reg       <= 10'h0_000;
      rb_valid_reg <= 1'b0;
      count_reg    <= 6'h00;
      raddr_reg    <= 6'h00;
      op_data_reg  <= 10'h0_000;
      low_cnt_reg  <= 8'h00;
      rp_meta_reg  <= 1'b1;
      rp_sync_reg  <= 1'b1;
      pm_meta_reg  <= 1'b0;
      pm_sync_reg  <= 1'b0;
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      busy_reg     <= (state_next != ST_IDLE);
      op_reg       <= op_next;
      cnt_reg      <= cnt_next;
      ack_reg      <= ack_next;
      wiper_reg    <= wiper_next;
      rb_reg       <= rb_next;
      rb_valid_reg <= rb_valid_next;
      count_reg    <= count_next;
      raddr_reg    <= raddr_next;
      op_data_reg  <= op_data_next;
      low_cnt_reg  <= low_cnt_next;
      rp_meta_reg  <= reset_pin_n;
      rp_sync_reg  <= rp_meta_reg;
      pm_meta_reg  <= perf_mode;
      pm_sync_reg  <= pm_meta_reg;
      req_meta_reg <= lk_req_reg;
      req_sync_reg <= req_meta_reg;
    end
  end

  assign wiper_setting_register = wiper_reg;
  assign readback_data          = rb_reg;
  assign readback_valid         = rb_valid_reg;
  assign programmed_count       = count_reg;
  assign busy                   = busy_reg;
endmodule : rct_core
`default_nettype wire

//--- rct_core_chk.sv
// Checker of the rheostat command core: timing seen at its ports.
// Assumes the short program, restore and power-up counts of the bench.
`timescale 1ns/1ps
`default_nettype none
module rct_core_chk #(
  parameter longint unsigned PROGRAM_CYC       = 100,
  parameter int unsigned     RESET_RESTORE_CYC = 80,
  parameter int unsigned     POWERUP_CYC       = 100
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       link_clk,
  input wire logic       link_rstn,
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       reset_pin_n,
  input wire logic       cmd_valid,
  input wire logic       cmd_pending,
  input wire logic       scl_clean,
  input wire logic       sda_clean,
  input wire logic [9:0] wiper_setting_register,
  input wire logic       readback_valid,
  input wire logic [5:0] programmed_count,
  input wire logic       busy
);
  localparam int     PU_LIM  = POWERUP_CYC + 10;
  localparam int     RR_LIM  = RESET_RESTORE_CYC + 12;
  localparam longint RUN_MAX = PROGRAM_CYC + 700;
  logic [15:0] run_reg;
  logic [15:0] run_next;
  // Busy run length: limits are judged on it since the code is in the link domain
  always_comb run_next = busy ? run_reg + 16'h0001 : 16'h0000;
  always_ff @(posedge clk) run_reg <= rstn ? run_next : 16'h0000;
  sequence pin_low_s;
    !reset_pin_n [*4];
  endsequence
  sequence midscale_s;
    wiper_setting_register == 10'h200 && !busy;
  endsequence
  chk_exec_floor: assert property (@(posedge clk) disable iff (!rstn)
    $fell(busy) |-> run_reg >= 16'h0032) else $error("command ended too early");
  chk_exec_ceiling: assert property (@(posedge clk) disable iff (!rstn)
    busy |-> run_reg <= RUN_MAX) else $error("command ran too long");
  chk_readback_done: assert property (@(posedge clk) disable iff (!rstn)
    $rose(readback_valid) |-> !busy) else $error("readback valid while busy");
  chk_wiper_cause: assert property (@(posedge clk) disable iff (!rstn)
    $changed(wiper_setting_register) |-> busy || $past(busy)) else $error("wiper moved idle");
  chk_powerup_mid: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> ##[1:PU_LIM] midscale_s) else $error("no power-up restore");
  chk_restore_mid: assert property (@(posedge clk) disable iff (!rstn)
    pin_low_s ##1 programmed_count == 6'h00 |-> ##[1:RR_LIM] midscale_s)
    else $error("no midscale restore");
  chk_restore_busy: assert property (@(posedge clk) disable iff (!rstn)
    pin_low_s |-> ##[0:4] busy) else $error("reset pin ignored");
  chk_scl_filter: assert property (@(posedge clk) disable iff (!rstn)
    $changed(scl_clean) |-> $past(scl, 3) == scl_clean && $past(scl, 6) == scl_clean)
    else $error("scl spike passed");
  chk_sda_filter: assert property (@(posedge clk) disable iff (!rstn)
    $changed(sda_clean) |-> $past(sda, 3) == sda_clean && $past(sda, 6) == sda_clean)
    else $error("sda spike passed");
  chk_cmd_take: assert property (@(posedge link_clk) disable iff (!link_rstn)
    cmd_valid && !cmd_pending |=> cmd_pending) else $error("command not taken");
endmodule : rct_core_chk
bind rct_core rct_core_chk #(.PROGRAM_CYC(PROGRAM_CYC), .RESET_RESTORE_CYC(RESET_RESTORE_CYC),
  .POWERUP_CYC(POWERUP_CYC)) chk_u (.clk(clk), .rstn(rstn), .link_clk(link_clk),
  .link_rstn(link_rstn), .scl(scl), .sda(sda), .reset_pin_n(reset_pin_n),
  .cmd_valid(cmd_valid), .cmd_pending(cmd_pending), .scl_clean(scl_clean),
  .sda_clean(sda_clean), .wiper_setting_register(wiper_setting_register),
  .readback_valid(readback_valid), .programmed_count(programmed_count), .busy(busy));
`default_nettype wire

//--- rct_host_model.sv
// Two-wire host model: link commands, serial pins and the reset pin.
// Assumes the core's request and pending handshake on the link clock.
`timescale 1ns/1ps
`default_nettype none
module rct_host_model (
  input  wire logic            clk,
  input  wire logic            link_clk,
  input  wire logic            cmd_pending,
  output logic                 scl,
  output logic                 sda,
  output logic                 reset_pin_n,
  output logic                 perf_mode,
  output logic                 cmd_valid,
  output rct_pkg::rct_cmd_type cmd_code,
  output logic [9:0]           cmd_data
);
  // Pull-ups keep idle pins high
  initial begin
    scl         = 1'b1;
    sda         = 1'b1;
    reset_pin_n = 1'b1;
    perf_mode   = 1'b0;
    cmd_valid   = 1'b0;
    cmd_code    = rct_pkg::CMD_NOP;
    cmd_data    = 10'h000;
  end
  task automatic send(input rct_pkg::rct_cmd_type code, input logic [9:0] data, input logic pm);
    int n;
    n = 0;
    @(posedge link_clk);
    perf_mode <= pm;
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    cmd_data  <= data;
    do begin
      @(posedge link_clk);
      n++;
    end while (cmd_pending !== 1'b1 && n < 500);
    cmd_valid <= 1'b0;
    cmd_data  <= ~data;
    // Only acceptance by the core is waited out here, not the command's execution
    while (cmd_pending !== 1'b0 && n < 5000) begin
      @(posedge link_clk);
      n++;
    end
  endtask : send
  task automatic pulse(input int pin, input int len);
    @(posedge clk);
    if (pin == 0) scl <= 1'b0;
    else if (pin == 1) sda <= 1'b0;
    else reset_pin_n <= 1'b0;
    repeat (len) @(posedge clk);
    scl         <= 1'b1;
    sda         <= 1'b1;
    reset_pin_n <= 1'b1;
  endtask : pulse
endmodule : rct_host_model
`default_nettype wire

//--- rheostat_command_timing_tb.sv
// Self-checking bench of the rheostat command core with a host model.
// Assumes short program, restore and power-up counts set at the instance.
`timescale 1ns/1ps
`default_nettype none
module rheostat_command_timing_tb;
  logic                 clk = 1'b0;
  logic                 link_clk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 link_rstn = 1'b0;
  logic                 scl, sda, reset_pin_n, perf_mode, cmd_valid, cmd_pending;
  logic                 scl_clean, sda_clean, readback_valid, busy;
  rct_pkg::rct_cmd_type cmd_code;
  logic [9:0]           cmd_data, wiper, readback_data;
  logic [5:0]           programmed_count;
  logic [31:0]          seed = 32'h0000_088c;
  int                   num_errors = 0;
  int                   checked = 0;
  int                   run = 0;
  int                   last_run = 0;
  int                   lo_n [2] = '{0, 0};
  int                   store_q [$];
  int                   wiper_m;
  always #5 clk = ~clk;
  initial begin
    #3;
    forever #40 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    run <= (busy === 1'b1) ? run + 1 : 0;
    if (busy === 1'b0 && run != 0) last_run <= run;
    lo_n[0] <= lo_n[0] + (scl_clean === 1'b0);
    lo_n[1] <= lo_n[1] + (sda_clean === 1'b0);
  end
  rct_host_model host_u (.clk(clk), .link_clk(link_clk), .cmd_pending(cmd_pending), .scl(scl),
    .sda(sda), .reset_pin_n(reset_pin_n), .perf_mode(perf_mode), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data));
  rct_core #(.PROGRAM_CYC(100), .RESET_RESTORE_CYC(80), .POWERUP_CYC(100)) dut_u (
    .clk(clk), .rstn(rstn), .link_clk(link_clk), .link_rstn(link_rstn), .scl(scl), .sda(sda),
    .reset_pin_n(reset_pin_n), .perf_mode(perf_mode), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_pending(cmd_pending),
    .scl_clean(scl_clean), .sda_clean(sda_clean), .wiper_setting_register(wiper),
    .readback_data(readback_data), .readback_valid(readback_valid),
    .programmed_count(programmed_count), .busy(busy));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (8) @(posedge clk);
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check(busy, 0);
  endtask : wait_idle
  task automatic wr(input logic pm, input int lim);
    seed = xs(seed);
    wiper_m = seed[9:0];
    host_u.send(rct_pkg::CMD_WRITE_WIPER, seed[9:0], pm);
    // Pending drops once the core takes the command, so the result is awaited here
    wait_idle();
    @(posedge clk);
    check(wiper, wiper_m);
    check(last_run >= 50 && last_run <= lim + 1, 1);
  endtask : wr
  task automatic wrap_up();
    $display("checked=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    int n0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge link_clk);
    link_rstn <= 1'b1;
    wait_idle();
    check(wiper, 10'h200);
    check(programmed_count, 6'h00);
    $display("test power-up done");
    for (int i = 0; i < 4; i++) wr(i[0], i[0] ? 200 : 60);
    host_u.pulse(2, 5);
    wait_idle();
    check(wiper, 10'h200);
    $display("test writes done");
    for (int i = 0; i < 2; i++) begin
      wr(1'b0, 60);
      host_u.send(rct_pkg::CMD_PROGRAM_STORE, 10'h000, 1'b0);
      wait_idle();
      @(posedge clk);
      store_q.push_back(wiper_m);
      check(programmed_count, store_q.size());
      check(wiper, wiper_m);
    end
    host_u.send(rct_pkg::CMD_READ_STORE, 10'h000, 1'b0);
    wait_idle();
    @(posedge clk);
    check(readback_valid, 1);
    check(readback_data, store_q[0]);
    check(last_run >= 50 && last_run <= 601, 1);
    $display("test store done");
    wr(1'b0, 60);
    // A 10 ns pulse is below the minimum and must leave the wiper alone
    host_u.pulse(2, 1);
    repeat (20) @(posedge clk);
    check(wiper, wiper_m);
    host_u.pulse(2, 5);
    wait_idle();
    check(wiper, store_q[$]);
    $display("test reset pin done");
    for (int p = 0; p < 2; p++) begin
      n0 = lo_n[p];
      host_u.pulse(p, 4);
      repeat (16) @(posedge clk);
      check(lo_n[p] - n0, 0);
      host_u.pulse(p, 10);
      repeat (16) @(posedge clk);
      check(lo_n[p] > n0, 1);
    end
    $display("test filters done");
    wrap_up();
  end
  initial begin
    #200_000;
    num_errors++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule : rheostat_command_timing_tb
`default_nettype wire
